// ===== hw/sl1c_defs.svh
/*
  Constants for the split first-level cache: index and tag fields, line
  geometry and cache-error source codes.
  Assumes inclusion by bare name from design files under hw/.
*/
`ifndef SL1C_DEFS_SVH
`define SL1C_DEFS_SVH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define SL1C_WORDS      4
`define SL1C_IC_LINES   128
`define SL1C_DC_LINES   64
`define SL1C_TAG_LO     10
`define SL1C_TAG_W      22
// ----------------------------------------
// Tag bit positions
// ----------------------------------------
`define SL1C_TAG_V      22
`define SL1C_TAG_P      23
`define SL1C_TAG_D      24
`define SL1C_TAG_DP     25
// ----------------------------------------
// Error source codes
// ----------------------------------------
`define SL1C_ERR_NONE   3'h0
`define SL1C_ERR_IC     3'h1
`define SL1C_ERR_DC     3'h2
`define SL1C_ERR_MEM    3'h3
`define SL1C_ERR_WBDATA 3'h4
`define SL1C_ERR_WBTAG  3'h5
`define SL1C_ERR_OPTAG  3'h6
`endif

// ===== hw/sl1c_pkg.sv
/*
  Types for the split first-level cache.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sl1c_pkg;
  typedef enum logic [1:0] {SL1C_OP_LOAD, SL1C_OP_STORE, SL1C_OP_WBINV, SL1C_OP_INV} sl1c_op_t;
  typedef enum {SL1C_IDLE, SL1C_LOOK, SL1C_WB, SL1C_FILL, SL1C_DONE} sl1c_state_t;
endpackage : sl1c_pkg

// ===== hw/sl1c_parity.sv
/*
  Even parity over a word of configurable width.
  Assumes a purely combinational use.
*/
`timescale 1ns/1ps
`default_nettype none
module sl1c_parity #(
  parameter int W = 32
) (
  // Data in
  input  wire logic [W-1:0] data,
  // Parity out
  output logic              par
);
  if (W < 1) begin : g_width_chk
    $error("bad width");
  end
  assign par = ^data;
endmodule : sl1c_parity
`default_nettype wire

// ===== hw/sl1c_icache.sv
/*
  Direct-mapped instruction cache with tag and word parity.
  Assumes a one-word fetch per request and a line refill from memory.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sl1c_defs.svh"
module sl1c_icache import sl1c_pkg::*; #(
  parameter int LINES = `SL1C_IC_LINES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Fetch
  input  wire logic        fetch,
  input  wire logic [31:0] fetch_va,
  input  wire logic [31:0] fetch_pa,
  output logic             fetch_hit,
  output logic [31:0]      fetch_word,
  output logic             fetch_perr,
  // Refill write
  input  wire logic        fill_we,
  input  wire logic [1:0]  fill_wsel,
  input  wire logic [31:0] fill_word,
  input  wire logic        fill_last,
  // Invalidate by index
  input  wire logic        inv,
  input  wire logic [31:0] inv_va
);
  localparam int IW = $clog2(LINES);
  if (LINES != `SL1C_IC_LINES) begin : g_size_chk
    $error("instruction cache must hold 2 KB");
  end
  logic [23:0] tag_mem [LINES];
  logic [32:0] data_mem [LINES*4];
  logic [IW-1:0] idx;
  logic [23:0] tag_rd;
  logic [32:0] dat_rd;
  logic        tp;
  logic        dp;
  assign idx    = fetch_va[IW+3:4];
  assign tag_rd = tag_mem[idx];
  assign dat_rd = data_mem[{idx, fetch_va[3:2]}];
  assign tp = ^tag_rd;
  assign dp = ^dat_rd;
  // Combinational read: one clock
  assign fetch_hit  = fetch && tag_rd[`SL1C_TAG_V] &&
                      tag_rd[`SL1C_TAG_W-1:0] == fetch_pa[31:`SL1C_TAG_LO];
  assign fetch_word = dat_rd[31:0];
  assign fetch_perr = fetch && tag_rd[`SL1C_TAG_V] && (tp || (fetch_hit && dp));
  // Arrays have no reset: line states survive reset
  always_ff @(posedge mclk) begin
    if (fill_we) begin
      data_mem[{idx, fill_wsel}] <= {^fill_word, fill_word};
    end
    if (inv) begin
      tag_mem[inv_va[IW+3:4]] <= 24'h0;  // Software clears lines after power-up
    end
    if (fill_we && fill_last) begin
      tag_mem[idx] <= {^{1'b1, fetch_pa[31:`SL1C_TAG_LO]}, 1'b1, fetch_pa[31:`SL1C_TAG_LO]};
    end
  end
endmodule : sl1c_icache
`default_nettype wire

// ===== hw/sl1c_top.sv
/*
  Split first-level cache: instruction side in a child, data side here.
  Write-back data cache with parity, a refill/write-back sequencer and a
  cache error register. Assumes the pipeline holds its request until
  ready, and memory answers one word per cycle with mem_rvalid.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sl1c_defs.svh"
module sl1c_top import sl1c_pkg::*; #(
  parameter int DC_LINES = `SL1C_DC_LINES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Instruction fetch
  input  wire logic        if_req,
  input  wire logic [31:0] if_va,
  input  wire logic [31:0] if_pa,
  output logic             if_ready,
  output logic [31:0]      if_word,
  // Data access
  input  wire logic        d_req,
  input  wire sl1c_op_t    d_op,
  input  wire logic [31:0] d_va,
  input  wire logic [31:0] d_pa,
  input  wire logic [31:0] d_wdata,
  output logic             d_ready,
  output logic [31:0]      d_rdata,
  // Memory side
  output logic             mem_rreq,
  output logic [31:0]      mem_raddr,
  input  wire logic        mem_rvalid,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_rperr,
  output logic             wb_valid,
  output logic [31:0]      wb_addr,
  output logic [3:0]       wb_addr_par,
  output logic [31:0]      wb_data,
  output logic             wb_data_par,
  // Cache error
  output logic             cache_err,
  output logic [2:0]       cache_error_register
);
  localparam int IW = $clog2(DC_LINES);
  if (DC_LINES != `SL1C_DC_LINES) begin : g_size_chk
    $error("data cache must hold 1 KB");
  end
  // ----------------------------------------
  // Data arrays, no reset
  // ----------------------------------------
  logic [25:0] dtag [DC_LINES];
  logic [32:0] ddat [DC_LINES*4];
  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  sl1c_state_t st;
  logic        side_i;                   // Refill owner: 1 = instruction
  logic [1:0]  wcnt;
  logic        ic_fill_we;
  logic        ic_fill_last;
  logic        fill_mem;
  // Pipelined store stage 2
  logic        st2_v;
  logic [IW+1:0] st2_a;
  logic [31:0] st2_d;
  // ----------------------------------------
  // Data lookup
  // ----------------------------------------
  logic [IW-1:0] didx;
  logic [25:0] dt;
  logic [32:0] dd;
  logic        dtag_perr;
  logic        ddat_perr;
  logic        dhit;
  logic        ddirty;
  logic        tag_par_err;
  logic        dirty_par_err;
  assign didx = d_va[IW+3:4];
  assign dt   = dtag[didx];
  assign dd   = ddat[{didx, d_va[3:2]}];
  sl1c_parity #(.W(24)) u_tpar (.data(dt[23:0]), .par(tag_par_err));
  sl1c_parity #(.W(33)) u_dpar (.data(dd), .par(ddat_perr));
  sl1c_parity #(.W(2))  u_dirp (.data(dt[25:24]), .par(dirty_par_err));
  // A bad dirty bit could lose a write-back, so it counts as a tag error
  assign dtag_perr = tag_par_err || dirty_par_err;
  assign dhit   = dt[`SL1C_TAG_V] && dt[21:0] == d_pa[31:`SL1C_TAG_LO];
  assign ddirty = dt[`SL1C_TAG_V] && dt[`SL1C_TAG_D];
  // Instruction side
  logic        ihit;
  logic [31:0] iword;
  logic        iperr;
  logic        ic_inv;
  sl1c_icache u_ic (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .fetch      (if_req),
    .fetch_va   (if_va),
    .fetch_pa   (if_pa),
    .fetch_hit  (ihit),
    .fetch_word (iword),
    .fetch_perr (iperr),
    .fill_we    (ic_fill_we),
    .fill_wsel  (wcnt),
    .fill_word  (mem_rdata),
    .fill_last  (ic_fill_last),
    .inv        (ic_inv),
    .inv_va     (d_va)
  );
  assign fill_mem     = st == SL1C_FILL && mem_rvalid;
  assign ic_fill_we   = fill_mem && side_i;
  assign ic_fill_last = wcnt == 2'h3;
  // Data side request decode
  logic d_look;
  logic d_stall_st2;
  assign d_stall_st2 = st2_v && st2_a[IW+1:2] == didx; // Avoid reading a stale word being written
  assign d_look = st == SL1C_IDLE && d_req && !d_stall_st2 && !(d_ready);
  // Invalidate clears the line at this index in both caches
  assign ic_inv = d_look && d_op == SL1C_OP_INV;
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic ev_err;
  logic [2:0] ev_src;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= SL1C_IDLE;
      side_i   <= 1'b0;
      wcnt     <= 2'h0;
      mem_rreq <= 1'b0;
      mem_raddr <= 32'h0;
      wb_valid <= 1'b0;
      wb_addr  <= 32'h0;
      wb_addr_par <= 4'h0;
      wb_data  <= 32'h0;
      wb_data_par <= 1'b0;
      d_ready  <= 1'b0;
      d_rdata  <= 32'h0;
      if_ready <= 1'b0;
      if_word  <= 32'h0;
      st2_v    <= 1'b0;
      st2_a    <= '0;
      st2_d    <= 32'h0;
      ev_err   <= 1'b0;
      ev_src   <= `SL1C_ERR_NONE;
    end else begin
      d_ready  <= 1'b0;
      if_ready <= 1'b0;
      st2_v    <= 1'b0;
      ev_err   <= 1'b0;
      wb_valid <= 1'b0;
      case (st)
        SL1C_IDLE: begin
          if (d_look) begin
            if (d_op == SL1C_OP_INV) begin
              d_ready <= 1'b1;                     // Tag written blind, so a bad tag cannot block it
            end else if (dt[`SL1C_TAG_V] && dtag_perr) begin
              ev_err  <= 1'b1;
              ev_src  <= (d_op == SL1C_OP_LOAD || d_op == SL1C_OP_STORE) ? `SL1C_ERR_DC : `SL1C_ERR_OPTAG;
              d_ready <= 1'b1;                     // Abandoned
            end else if (d_op == SL1C_OP_LOAD && dhit) begin
              d_rdata <= dd[31:0];
              d_ready <= 1'b1;
              if (ddat_perr) begin
                ev_err <= 1'b1;
                ev_src <= `SL1C_ERR_DC;
              end
            end else if (d_op == SL1C_OP_STORE && dhit) begin
              st2_v   <= 1'b1;
              st2_a   <= {didx, d_va[3:2]};
              st2_d   <= d_wdata;
              d_ready <= 1'b1;
            end else if (d_op == SL1C_OP_WBINV) begin
              if (ddirty) begin
                st <= SL1C_WB;
              end else begin
                d_ready <= 1'b1;
              end
              wcnt <= 2'h0;
            end else begin
              side_i <= 1'b0;                      // Miss
              wcnt   <= 2'h0;
              st     <= ddirty ? SL1C_WB : SL1C_FILL;
              mem_rreq  <= !ddirty;
              mem_raddr <= {d_pa[31:4], 4'h0};
            end
          end else if (if_req && !ihit && !iperr && !d_req) begin
            side_i    <= 1'b1;
            wcnt      <= 2'h0;
            st        <= SL1C_FILL;
            mem_rreq  <= 1'b1;
            mem_raddr <= {if_pa[31:4], 4'h0};
          end else if (if_req && iperr && !if_ready) begin
            ev_err   <= 1'b1;
            ev_src   <= `SL1C_ERR_IC;
            if_ready <= 1'b1;
          end else if (if_req && ihit && !if_ready) begin
            if_word  <= iword;
            if_ready <= 1'b1;
          end
        end
        SL1C_WB: begin
          if (wcnt == 2'h0 && dtag_perr) begin
            ev_err <= 1'b1;                        // No bus cycle
            ev_src <= `SL1C_ERR_WBTAG;
            d_ready <= 1'b1;
            st     <= SL1C_IDLE;
          end else begin
            wb_valid    <= 1'b1;
            wb_addr     <= {dt[21:0], didx, wcnt, 2'h0};
            wb_addr_par <= {^dt[21:14], ^dt[13:6], ^{dt[5:0], didx[IW-1:IW-2]}, ^{didx[IW-3:0], wcnt, 2'h0}};
            wb_data     <= ddat[{didx, wcnt}][31:0];
            wb_data_par <= ddat[{didx, wcnt}][32];
            if (^ddat[{didx, wcnt}]) begin
              ev_err <= 1'b1;                      // Still written out
              ev_src <= `SL1C_ERR_WBDATA;
            end
            wcnt <= wcnt + 2'h1;
            if (wcnt == 2'h3) begin
              if (d_op == SL1C_OP_WBINV) begin
                d_ready <= 1'b1;
                st      <= SL1C_IDLE;
              end else begin
                st        <= SL1C_FILL;
                mem_rreq  <= 1'b1;
                mem_raddr <= {d_pa[31:4], 4'h0};
              end
            end
          end
        end
        SL1C_FILL: begin
          mem_rreq <= 1'b0;
          if (mem_rvalid) begin
            wcnt <= wcnt + 2'h1;
            if (mem_rperr) begin
              ev_err <= 1'b1;
              ev_src <= `SL1C_ERR_MEM;
            end
            if (wcnt == 2'h3) begin
              st <= SL1C_DONE;
            end
          end
        end
        default: begin
          st <= SL1C_IDLE;                         // Rerun lookup, now a hit
        end
      endcase
    end
  end
  // ----------------------------------------
  // Data array writes
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (st2_v) begin
      ddat[st2_a] <= {^st2_d, st2_d};
      dtag[st2_a[IW+1:2]][25:24] <= 2'b11;         // Dirty plus its even parity
    end
    if (fill_mem && !side_i) begin
      ddat[{didx, wcnt}] <= {^mem_rdata, mem_rdata};
      if (wcnt == 2'h3) begin
        dtag[didx] <= {2'b00, ^{1'b1, d_pa[31:10]}, 1'b1, d_pa[31:10]}; // Valid clean
      end
    end
    if (ic_inv) begin
      dtag[didx] <= 26'h0;                         // Invalid with even parity
    end
    if (st == SL1C_WB && wcnt == 2'h3 && d_op == SL1C_OP_WBINV) begin
      dtag[didx] <= 26'h0;
    end
  end
  // ----------------------------------------
  // Cache error register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cache_err            <= 1'b0;
      cache_error_register <= `SL1C_ERR_NONE;
    end else begin
      cache_err <= ev_err;
      if (ev_err) begin
        cache_error_register <= ev_src;
      end
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  err_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ev_err |=> cache_err && cache_error_register == $past(ev_src)) else $error("error not recorded");
  fill_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == SL1C_FILL && mem_rvalid && wcnt == 2'h3) |=> st == SL1C_DONE) else $error("fill length wrong");
  wb_tag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == SL1C_WB && wcnt == 2'h0 && dtag_perr) |=> !wb_valid && ev_src == `SL1C_ERR_WBTAG) else $error("bad tag written");
  wb_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == SL1C_IDLE && d_look && d_op == SL1C_OP_LOAD && !dhit && ddirty && !(dt[`SL1C_TAG_V] && dtag_perr))
    |=> st == SL1C_WB) else $error("refill before write-back");
  load_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (d_look && d_op == SL1C_OP_LOAD && dhit && !dtag_perr) |=> d_ready && d_rdata == $past(dd[31:0]))
    else $error("load hit slow");
  store_pipe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (d_look && d_op == SL1C_OP_STORE && dhit && !dtag_perr) |=> st2_v) else $error("store not staged");
  wb_par_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wb_valid |-> wb_addr_par == {^wb_addr[31:24], ^wb_addr[23:16], ^wb_addr[15:8], ^wb_addr[7:0]})
    else $error("address parity wrong");
  wb_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == SL1C_WB && !(wcnt == 2'h0 && dtag_perr)) |=> wb_valid) else $error("write-back dropped");
  // ----------------------------------------
  // Sequencing checks
  // ----------------------------------------
  inv_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (d_look && d_op == SL1C_OP_INV) |=> d_ready && !dt[`SL1C_TAG_V]) else $error("line not invalidated");
  rreq_fill_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_rreq |-> st == SL1C_FILL) else $error("refill request outside fill");
  rreq_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_rreq |=> !mem_rreq) else $error("refill request repeated");
  rreq_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_rreq |-> mem_raddr[3:0] == 4'h0) else $error("refill address not line aligned");
  wb_from_wb_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wb_valid |-> $past(st) == SL1C_WB) else $error("write-back outside write-back state");
  wb_dirty_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == SL1C_WB && wcnt == 2'h0) |-> ddirty) else $error("clean line written back");
  wbinv_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == SL1C_WB && wcnt == 2'h3 && d_op == SL1C_OP_WBINV) |=> d_ready && !dt[`SL1C_TAG_V])
    else $error("written-back line kept");
  tag_abandon_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (d_look && d_op != SL1C_OP_INV && dt[`SL1C_TAG_V] && dtag_perr) |=> d_ready && ev_err && st == SL1C_IDLE &&
    !st2_v && !mem_rreq) else $error("bad tag not abandoned");
  fetch_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == SL1C_IDLE && !d_look && if_req && ihit && !iperr && !if_ready) |=> if_ready && if_word == $past(iword))
    else $error("fetch hit slow");
  mem_perr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == SL1C_FILL && mem_rvalid && mem_rperr) |=> ev_err && ev_src == `SL1C_ERR_MEM)
    else $error("memory parity error lost");
endmodule : sl1c_top
`default_nettype wire

// ===== tb/sl1c_mem_model.sv
/*
  Main-memory model on the refill side of the split cache.
  Assumes one line refill at a time and a request only while idle.
*/
`timescale 1ns/1ps
`default_nettype none
module sl1c_mem_model (
  // Clock
  input  wire logic        mclk,
  // Refill request
  input  wire logic        mem_rreq,
  input  wire logic [31:0] mem_raddr,
  // Refill answer
  output logic             mem_rvalid,
  output logic [31:0]      mem_rdata,
  output logic             mem_rperr,
  // Test controls
  input  wire logic [1:0]  gap,
  input  wire logic        perr_en,
  input  wire logic [1:0]  perr_word
);
  // ----------------------------------------
  // Memory contents
  // ----------------------------------------
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[31:2], 2'h0} ^ 32'h5A5AC3C3;
  endfunction : mem_word

  logic [31:0] line;

  initial begin
    mem_rvalid = 1'h0;
    mem_rdata  = 32'h0;
    mem_rperr  = 1'h0;
  end

  // ----------------------------------------
  // Refill, word 0 first
  // ----------------------------------------
  // Idle data shows the inverse of the last word, so a stale read never matches
  always begin
    @(posedge mclk);
    if (mem_rreq === 1'h1) begin
      line = mem_raddr;
      for (int i = 0; i < 4; i++) begin
        repeat (gap) @(posedge mclk);
        mem_rvalid <= 1'h1;
        mem_rdata  <= mem_word(line + 32'(4 * i));
        mem_rperr  <= perr_en && (perr_word == 2'(i));
        @(posedge mclk);
        // Back-to-back words keep valid up, so nothing is driven twice in one step
        if (i == 3 || gap != 2'h0) begin
          mem_rvalid <= 1'h0;
          mem_rperr  <= 1'h0;
          mem_rdata  <= ~mem_word(line + 32'(4 * i));
        end
      end
    end
  end
endmodule : sl1c_mem_model
`default_nettype wire

// ===== tb/tb_sl1c_top.sv
/*
  Self-checking bench for the split first-level cache.
  Assumes the memory model answers refills and that the arrays start unknown.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sl1c_defs.svh"
module tb_sl1c_top import sl1c_pkg::*;;
  logic        mclk, rst_n, if_req, if_ready, d_req, d_ready, mem_rreq, mem_rvalid, mem_rperr;
  logic        wb_valid, wb_data_par, cache_err, perr_en;
  logic [31:0] if_va, if_pa, if_word, d_va, d_pa, d_wdata, d_rdata, mem_raddr, mem_rdata;
  logic [31:0] wb_addr, wb_data, last_raddr, rd;
  logic [31:0] wb_a[$], wb_d[$];
  logic [3:0]  wb_addr_par;
  logic [2:0]  cache_error_register;
  logic [1:0]  gap, perr_word;
  sl1c_op_t    d_op;
  int          fail_count, samples_checked, rreq_n, wb_n, wb_at_rreq, err_n, lat;

  sl1c_top u_sl1c_top (.mclk(mclk), .rst_n(rst_n), .if_req(if_req), .if_va(if_va), .if_pa(if_pa),
    .if_ready(if_ready), .if_word(if_word), .d_req(d_req), .d_op(d_op), .d_va(d_va), .d_pa(d_pa),
    .d_wdata(d_wdata), .d_ready(d_ready), .d_rdata(d_rdata), .mem_rreq(mem_rreq),
    .mem_raddr(mem_raddr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_rperr(mem_rperr),
    .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_addr_par(wb_addr_par), .wb_data(wb_data),
    .wb_data_par(wb_data_par), .cache_err(cache_err), .cache_error_register(cache_error_register));
  sl1c_mem_model u_sl1c_mem_model (.mclk(mclk), .mem_rreq(mem_rreq), .mem_raddr(mem_raddr),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_rperr(mem_rperr), .gap(gap),
    .perr_en(perr_en), .perr_word(perr_word));

  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] mw(input logic [31:0] a);
    return u_sl1c_mem_model.mem_word(a);
  endfunction : mw

  task automatic do_reset;
    rst_n <= 1'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (2) @(posedge mclk);
  endtask : do_reset

  // Request held until ready, dropped in the cycle after it
  task automatic dacc(input sl1c_op_t op, input logic [31:0] va, input logic [31:0] pa,
                      input logic [31:0] wd);
    d_req <= 1'h1;
    d_op <= op;
    d_va <= va;
    d_pa <= pa;
    d_wdata <= wd;
    lat = 0;
    do begin
      @(posedge mclk);
      lat++;
    end while (d_ready !== 1'h1 && lat < 300);
    rd = d_rdata;
    d_req <= 1'h0;
    if (lat >= 300) check(32'h0, 32'h1);
    @(posedge mclk);
  endtask : dacc

  task automatic facc(input logic [31:0] va, input logic [31:0] pa);
    if_req <= 1'h1;
    if_va <= va;
    if_pa <= pa;
    lat = 0;
    do begin
      @(posedge mclk);
      lat++;
    end while (if_ready !== 1'h1 && lat < 300);
    rd = if_word;
    if_req <= 1'h0;
    if (lat >= 300) check(32'h0, 32'h1);
    @(posedge mclk);
  endtask : facc

  // ----------------------------------------
  // Memory-side monitor
  // ----------------------------------------
  always @(posedge mclk) begin
    if (wb_valid === 1'h1) begin
      wb_n++;
      wb_a.push_back(wb_addr);
      wb_d.push_back(wb_data);
      for (int i = 0; i < 4; i++) check(32'(wb_addr_par[i]), 32'(^wb_addr[8*i+:8]));
      check(32'(wb_data_par), 32'(^wb_data));
    end
    // Counted after write-backs: a request beside the last word sees all four
    if (mem_rreq === 1'h1) begin
      rreq_n++;
      last_raddr = mem_raddr;
      wb_at_rreq = wb_n;
    end
    if (cache_err === 1'h1) err_n++;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_miss_then_hit;
    int n;
    n = rreq_n;
    dacc(SL1C_OP_LOAD, 32'h00000234, 32'h00001234, 32'h0);
    check(32'(rreq_n - n), 32'h1);
    check(last_raddr, 32'h00001230);
    check(rd, mw(32'h00001234));
    dacc(SL1C_OP_LOAD, 32'h00000238, 32'h00001238, 32'h0);
    check(32'(rreq_n - n), 32'h1);
    check(32'(lat), 32'h2);
    check(rd, mw(32'h00001238));
  endtask : t_miss_then_hit

  task automatic t_store_victim;
    int n;
    n = wb_n;
    dacc(SL1C_OP_STORE, 32'h00000234, 32'h00001234, 32'hCAFE0001);
    check(32'(lat), 32'h2);
    dacc(SL1C_OP_LOAD, 32'h00000234, 32'h00001234, 32'h0);
    check(rd, 32'hCAFE0001);
    check(32'(wb_n - n), 32'h0);
    // VA bit 10 lies outside the data index, so this evicts the dirty line
    dacc(SL1C_OP_LOAD, 32'h00000634, 32'h00002234, 32'h0);
    check(32'(wb_n - n), 32'h4);
    check(32'(wb_at_rreq - n), 32'h4);
    for (int i = 0; i < 4; i++) begin
      check(wb_a[n+i], 32'h00001230 + 32'(4 * i));
      check(wb_d[n+i], (i == 1) ? 32'hCAFE0001 : mw(32'h00001230 + 32'(4 * i)));
    end
    check(rd, mw(32'h00002234));
  endtask : t_store_victim

  task automatic t_wbinv_slow;
    int n;
    gap <= 2'h2;
    dacc(SL1C_OP_STORE, 32'h00000634, 32'h00002234, 32'hBEEF0002);
    n = wb_n;
    dacc(SL1C_OP_WBINV, 32'h00000634, 32'h00002234, 32'h0);
    check(32'(wb_n - n), 32'h4);
    check(wb_d[n+1], 32'hBEEF0002);
    n = rreq_n;
    dacc(SL1C_OP_LOAD, 32'h00000634, 32'h00002234, 32'h0);
    check(32'(rreq_n - n), 32'h1);
    check(rd, mw(32'h00002234));
    gap <= 2'h0;
  endtask : t_wbinv_slow

  task automatic t_reset_keeps;
    int n;
    n = rreq_n;
    do_reset();
    dacc(SL1C_OP_LOAD, 32'h00000634, 32'h00002234, 32'h0);
    check(32'(rreq_n - n), 32'h0);
    check(rd, mw(32'h00002234));
  endtask : t_reset_keeps

  task automatic t_mem_perr;
    int n;
    n = err_n;
    perr_en <= 1'h1;
    perr_word <= 2'h2;
    dacc(SL1C_OP_LOAD, 32'h00000340, 32'h00003340, 32'h0);
    perr_en <= 1'h0;
    repeat (2) @(posedge mclk);
    check(32'(err_n - n), 32'h1);
    check(32'(cache_error_register), 32'(`SL1C_ERR_MEM));
  endtask : t_mem_perr

  task automatic t_fetch;
    int n;
    n = rreq_n;
    facc(32'h00000570, 32'h00004570);
    check(32'(rreq_n - n), 32'h1);
    check(rd, mw(32'h00004570));
    facc(32'h00000574, 32'h00004574);
    check(32'(lat), 32'h2);
    check(32'(rreq_n - n), 32'h1);
    check(rd, mw(32'h00004574));
  endtask : t_fetch

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {rst_n, if_req, d_req, perr_en} = 4'h0;
    {if_va, if_pa, d_va, d_pa, d_wdata} = '0;
    d_op = SL1C_OP_LOAD;
    gap = 2'h0;
    perr_word = 2'h0;
    {fail_count, samples_checked, rreq_n, wb_n, wb_at_rreq, err_n} = '0;
    @(posedge mclk);
    do_reset();
    // Arrays power up unknown; invalidate clears both caches at each index
    for (int i = 0; i < 128; i++) dacc(SL1C_OP_INV, 32'(i * 16), 32'(i * 16), 32'h0);
    t_miss_then_hit();
    t_store_victim();
    t_wbinv_slow();
    t_reset_keeps();
    t_mem_perr();
    t_fetch();
    report_and_stop();
  end

  initial begin
    #(30000 * 100);
    fail_count++;
    report_and_stop();
  end
endmodule : tb_sl1c_top
`default_nettype wire
